// ===== nrlc_pkg.sv
// Purpose: shared constants and helpers for the reader line coder
// Assumes: carrier clock is the 13.56 MHz RF clock
// Notes:   bit lengths are counted in carrier cycles
package nrlc_pkg;
   localparam int         FIFO_W     = 2;
   localparam int         FIFO_D     = 16;
   localparam int         WORD_BIT   = 0;
   localparam int         WORD_LAST  = 1;
   // reader modes
   localparam logic [2:0] MODE_A     = 3'h0;
   localparam logic [2:0] MODE_T1    = 3'h1;
   localparam logic [2:0] MODE_T3    = 3'h2;
   localparam logic [2:0] MODE_B     = 3'h3;
   localparam logic [2:0] MODE_T5    = 3'h4;
   // rate codes
   localparam logic [1:0] RATE_106   = 2'h0;
   localparam logic [1:0] RATE_212   = 2'h1;
   localparam logic [1:0] RATE_424   = 2'h2;
   localparam logic [1:0] RATE_848   = 2'h3;
   // bit lengths in carrier cycles
   localparam logic [9:0] LEN_BASE   = 10'h080;
   localparam logic [9:0] LEN_T5     = 10'h200;
   // subcarrier of carrier/16, phase sample point
   localparam logic [9:0] SC_LEN     = 10'h010;
   localparam logic [9:0] SC_SAMPLE  = 10'h004;
   localparam logic [9:0] EDGE_MIN   = 10'h002;
   // modulation depth classes
   localparam logic [1:0] DEP_FULL   = 2'h0;
   localparam logic [1:0] DEP_ASK25  = 2'h1;
   localparam logic [1:0] DEP_ASK_B  = 2'h2;
   localparam logic [1:0] DEP_ASK_T3 = 2'h3;

   function automatic logic [9:0] bit_len(input logic [2:0] mode, input logic [1:0] rate);
      logic [1:0] r;
      r = rate;
      if (mode == MODE_T3)
      begin
         r = (rate == RATE_106) ? RATE_212 : ((rate == RATE_848) ? RATE_424 : rate);
      end
      if (mode == MODE_T5)
      begin
         bit_len = LEN_T5;
      end
      else
      begin
         bit_len = LEN_BASE >> r;
      end
   endfunction

   function automatic logic [1:0] depth_of(input logic [2:0] mode, input logic [1:0] rate);
      case (mode)
         MODE_A, MODE_T1: depth_of = (rate == RATE_106) ? DEP_FULL : DEP_ASK25;
         MODE_B:          depth_of = DEP_ASK_B;
         MODE_T3:         depth_of = DEP_ASK_T3;
         default:         depth_of = DEP_FULL;
      endcase
   endfunction
endpackage

// ===== nrlc_fifo.sv
// Purpose: transmit bit buffer with registered read data
// Assumes: single clock, depth a power of two
// Notes:   show-ahead output register
`timescale 1ns/1ps
module nrlc_fifo #(
   parameter int WIDTH = nrlc_pkg::FIFO_W,
   parameter int DEPTH = nrlc_pkg::FIFO_D
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             ce_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_q;
   logic [AW-1:0]    wptr_d;
   logic [AW-1:0]    rptr_q;
   logic [AW-1:0]    rptr_d;
   logic [CW-1:0]    count_q;
   logic [CW-1:0]    count_d;
   logic             vld_q;
   logic             vld_d;
   logic             rdy_q;
   logic             rdy_d;
   logic [WIDTH-1:0] dat_q;
   logic             push;
   logic             load;

   always_comb
   begin
      push    = in_valid_in && rdy_q;
      load    = (count_q != '0) && (!vld_q || out_ready_in);
      wptr_d  = push ? wptr_q + 1'b1 : wptr_q;
      rptr_d  = load ? rptr_q + 1'b1 : rptr_q;
      count_d = count_q;
      if (push)
      begin
         count_d = count_d + 1'b1;
      end
      if (load)
      begin
         count_d = count_d - 1'b1;
      end
      vld_d = load ? 1'b1 : (out_ready_in ? 1'b0 : vld_q);
      rdy_d = count_d != CW'(DEPTH);
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         count_q <= '0;
         vld_q   <= 1'b0;
         rdy_q   <= 1'b1;
         dat_q   <= '0;
      end
      else if (ce_in)
      begin
         wptr_q  <= wptr_d;
         rptr_q  <= rptr_d;
         count_q <= count_d;
         vld_q   <= vld_d;
         rdy_q   <= rdy_d;
         if (load)
         begin
            dat_q <= mem[rptr_q];
         end
      end
      if (ce_in && push)
      begin
         mem[wptr_q] <= in_data_in;
      end
   end

   assign in_ready_out  = rdy_q;
   assign out_valid_out = vld_q;
   assign out_data_out  = dat_q;

   property full_p;
      @(posedge clk_in) disable iff (!rst_n_in)
      (count_q == CW'(DEPTH)) |-> !rdy_q;
   endproperty
   fifo_full_a: assert property (full_p) else $error("fifo full but ready");
   fifo_full_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) !rdy_q);
endmodule // nrlc_fifo

// ===== nrlc_top.sv
// Purpose: reader-mode line coder, host bits to carrier modulation and back
// Assumes: CARRIER_CLK_IN is the 13.56 MHz carrier, mode/rate changed only while idle
// Notes:   transmit bits buffered, crossing by a req/ack toggle handshake, receive bits by a toggle without ack
`timescale 1ns/1ps
module nrlc_top (
   input  wire logic       CLOCK_IN,
   input  wire logic       RSTN_IN,
   input  wire logic       CE_IN,
   input  wire logic       CARRIER_CLK_IN,
   input  wire logic [2:0] MODE_IN,
   input  wire logic [1:0] RATE_IN,
   input  wire logic       TX_VALID_IN,
   input  wire logic       TX_BIT_IN,
   input  wire logic       TX_LAST_IN,
   output logic            TX_READY_OUT,
   input  wire logic       LOAD_IN,
   output logic            MOD_OUT,
   output logic      [1:0] MOD_DEPTH_OUT,
   output logic            RX_VALID_OUT,
   output logic            RX_BIT_OUT,
   output logic            RX_END_OUT
);
   typedef enum logic {TX_IDLE = 1'b0, TX_BIT = 1'b1} nrlc_tx_e;
   typedef enum logic {RX_IDLE = 1'b0, RX_RUN = 1'b1} nrlc_rx_e;

   // carrier domain
   logic       rst_s1, rst_s2, ce_s1, ce_s2, req_s1, req_s2;
   logic       ld_s1, ld_s2, ld_s3;
   logic [4:0] cfg_s1, cfg_s2;
   logic [2:0] cmode;
   logic [1:0] crate;
   logic [9:0] len, half, qtr, eig;
   logic       pend, tend, rend, rise, edg, rbit;
   nrlc_tx_e   tx_st_q, tx_st_d;
   nrlc_rx_e   rx_st_q, rx_st_d;
   logic [9:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
   logic [9:0] e1_q, e1_d, e2_q, e2_d, h1_q, h1_d, h2_q, h2_d;
   logic       tbit_q, tbit_d, tlast_q, tlast_d, tprev_q, tprev_d;
   logic       seen_q, seen_d, mod_q, mod_d;
   logic [1:0] dep_q, dep_d, rxdat_q, rxdat_d;
   logic       samp_q, samp_d, ref_q, ref_d, first_q, first_d;
   logic       rxtog_q, rxtog_d;
   // host domain
   logic       ack_s1, ack_s2, rxt_s1, rxt_s2;
   logic       free, take, rxnew, f_vld;
   logic [1:0] f_dat;
   logic       req_q, req_d, rxseen_q, rxseen_d;
   logic [1:0] word_q, word_d;
   logic       rxv_q, rxv_d, rxb_q, rxb_d, rxe_q, rxe_d;

   nrlc_fifo #(
      .WIDTH (nrlc_pkg::FIFO_W),
      .DEPTH (nrlc_pkg::FIFO_D)
   ) u_fifo (
      .clk_in        (CLOCK_IN),
      .rst_n_in      (RSTN_IN),
      .ce_in         (CE_IN),
      .in_valid_in   (TX_VALID_IN),
      .in_data_in    ({TX_LAST_IN, TX_BIT_IN}),
      .in_ready_out  (TX_READY_OUT),
      .out_valid_out (f_vld),
      .out_data_out  (f_dat),
      .out_ready_in  (free)
   );

   // carrier synchronisers
   always_ff @(posedge CARRIER_CLK_IN)
   begin
      rst_s1 <= RSTN_IN;
      rst_s2 <= rst_s1;
      ce_s1  <= CE_IN;
      ce_s2  <= ce_s1;
      cfg_s1 <= {MODE_IN, RATE_IN};
      cfg_s2 <= cfg_s1;
      req_s1 <= req_q;
      req_s2 <= req_s1;
      ld_s1  <= LOAD_IN;
      ld_s2  <= ld_s1;
      ld_s3  <= ld_s2;
   end

   always_comb
   begin
      cmode   = cfg_s2[4:2];
      crate   = cfg_s2[1:0];
      len     = nrlc_pkg::bit_len(cmode, crate);
      half    = len >> 1;
      qtr     = len >> 2;
      eig     = len >> 3;
      pend    = req_s2 != seen_q;
      tend    = tcnt_q == len - 1'b1;
      rend    = rcnt_q == len - 1'b1;
      rise    = ld_s2 && !ld_s3;
      edg     = ld_s2 != ld_s3;
      tx_st_d = tx_st_q;
      tcnt_d  = tcnt_q + 1'b1;
      tbit_d  = tbit_q;
      tlast_d = tlast_q;
      tprev_d = tprev_q;
      seen_d  = seen_q;
      case (tx_st_q)
         TX_IDLE:
         begin
            tcnt_d  = '0;
            tprev_d = 1'b0;
            if (pend)
            begin
               tx_st_d = TX_BIT;
               tbit_d  = word_q[nrlc_pkg::WORD_BIT];
               tlast_d = word_q[nrlc_pkg::WORD_LAST];
               seen_d  = req_s2;
            end
         end
         TX_BIT:
         begin
            if (tend)
            begin
               tcnt_d  = '0;
               tprev_d = tbit_q;
               if (!tlast_q && pend)
               begin
                  tbit_d  = word_q[nrlc_pkg::WORD_BIT];
                  tlast_d = word_q[nrlc_pkg::WORD_LAST];
                  seen_d  = req_s2;
               end
               else
               begin
                  tx_st_d = TX_IDLE;
               end
            end
         end
         default: tx_st_d = TX_IDLE;
      endcase
      mod_d = 1'b0;
      if (tx_st_q == TX_BIT)
      begin
         case (cmode)
            nrlc_pkg::MODE_A, nrlc_pkg::MODE_T1:
               mod_d = tbit_q ? (tcnt_q >= half && tcnt_q < half + qtr)
                              : (!tprev_q && tcnt_q < qtr);
            nrlc_pkg::MODE_T3: mod_d = (tcnt_q >= half) == tbit_q;
            nrlc_pkg::MODE_B:  mod_d = !tbit_q;
            nrlc_pkg::MODE_T5:
               mod_d = tbit_q ? (tcnt_q >= half + qtr && tcnt_q < half + qtr + eig)
                              : (tcnt_q >= qtr && tcnt_q < qtr + eig);
            default: mod_d = 1'b0;
         endcase
      end
      dep_d     = nrlc_pkg::depth_of(cmode, crate);
      rx_st_d   = rx_st_q;
      rcnt_d    = rcnt_q + 1'b1;
      e1_d      = e1_q;
      e2_d      = e2_q;
      h1_d      = h1_q;
      h2_d      = h2_q;
      samp_d    = samp_q;
      ref_d     = ref_q;
      first_d   = first_q;
      rxdat_d   = rxdat_q;
      rxtog_d   = rxtog_q;
      rbit      = 1'b0;
      case (rx_st_q)
         RX_IDLE:
         begin
            rcnt_d  = '0;
            e1_d    = '0;
            e2_d    = '0;
            h1_d    = '0;
            h2_d    = '0;
            first_d = 1'b1;
            if (tx_st_q == TX_IDLE && rise)
            begin
               rx_st_d = RX_RUN;
            end
         end
         RX_RUN:
         begin
            if (edg && rcnt_q < half)
            begin
               e1_d = e1_q + 1'b1;
            end
            if (edg && rcnt_q >= half)
            begin
               e2_d = e2_q + 1'b1;
            end
            if (ld_s2 && rcnt_q < half)
            begin
               h1_d = h1_q + 1'b1;
            end
            if (ld_s2 && rcnt_q >= half)
            begin
               h2_d = h2_q + 1'b1;
            end
            if (rcnt_q == nrlc_pkg::SC_SAMPLE)
            begin
               samp_d = ld_s2;
            end
            if (rend)
            begin
               rcnt_d  = '0;
               e1_d    = '0;
               e2_d    = '0;
               h1_d    = '0;
               h2_d    = '0;
               first_d = 1'b0;
               rxtog_d = !rxtog_q;
               case (cmode)
                  nrlc_pkg::MODE_T3: rbit = h1_q > h2_q;
                  nrlc_pkg::MODE_B:  rbit = !first_q && (samp_q != ref_q);
                  nrlc_pkg::MODE_T5: rbit = e1_q >= nrlc_pkg::EDGE_MIN;
                  default:
                     rbit = (crate == nrlc_pkg::RATE_106) ? (e1_q >= nrlc_pkg::EDGE_MIN)
                                                          : (!first_q && (samp_q != ref_q));
               endcase
               if (e1_q == '0 && e2_q == '0)
               begin
                  rxdat_d = 2'h2;
                  rx_st_d = RX_IDLE;
               end
               else
               begin
                  rxdat_d = {1'b0, rbit};
                  ref_d   = first_q ? samp_q : ref_q;
               end
            end
         end
         default: rx_st_d = RX_IDLE;
      endcase
   end

   always_ff @(posedge CARRIER_CLK_IN)
   begin
      if (!rst_s2)
      begin
         tx_st_q <= TX_IDLE;
         rx_st_q <= RX_IDLE;
         tcnt_q  <= '0;
         rcnt_q  <= '0;
         e1_q    <= '0;
         e2_q    <= '0;
         h1_q    <= '0;
         h2_q    <= '0;
         tbit_q  <= 1'b0;
         tlast_q <= 1'b0;
         tprev_q <= 1'b0;
         seen_q  <= 1'b0;
         mod_q   <= 1'b0;
         dep_q   <= nrlc_pkg::DEP_FULL;
         samp_q  <= 1'b0;
         ref_q   <= 1'b0;
         first_q <= 1'b1;
         rxdat_q <= '0;
         rxtog_q <= 1'b0;
      end
      else if (ce_s2)
      begin
         tx_st_q <= tx_st_d;
         rx_st_q <= rx_st_d;
         tcnt_q  <= tcnt_d;
         rcnt_q  <= rcnt_d;
         e1_q    <= e1_d;
         e2_q    <= e2_d;
         h1_q    <= h1_d;
         h2_q    <= h2_d;
         tbit_q  <= tbit_d;
         tlast_q <= tlast_d;
         tprev_q <= tprev_d;
         seen_q  <= seen_d;
         mod_q   <= mod_d;
         dep_q   <= dep_d;
         samp_q  <= samp_d;
         ref_q   <= ref_d;
         first_q <= first_d;
         rxdat_q <= rxdat_d;
         rxtog_q <= rxtog_d;
      end
   end

   always_comb
   begin
      free     = ack_s2 == req_q;
      take     = f_vld && free;
      req_d    = take ? !req_q : req_q;
      word_d   = take ? f_dat : word_q;
      rxnew    = rxt_s2 != rxseen_q;
      rxseen_d = rxt_s2;
      rxv_d    = rxnew;
      rxb_d    = rxnew ? rxdat_q[0] : rxb_q;
      rxe_d    = rxnew ? rxdat_q[1] : rxe_q;
   end

   always_ff @(posedge CLOCK_IN)
   begin
      ack_s1 <= seen_q;
      ack_s2 <= ack_s1;
      rxt_s1 <= rxtog_q;
      rxt_s2 <= rxt_s1;
      if (!RSTN_IN)
      begin
         req_q    <= 1'b0;
         word_q   <= '0;
         rxseen_q <= 1'b0;
         rxv_q    <= 1'b0;
         rxb_q    <= 1'b0;
         rxe_q    <= 1'b0;
      end
      else if (CE_IN)
      begin
         req_q    <= req_d;
         word_q   <= word_d;
         rxseen_q <= rxseen_d;
         rxv_q    <= rxv_d;
         rxb_q    <= rxb_d;
         rxe_q    <= rxe_d;
      end
   end

   assign MOD_OUT       = mod_q;
   assign MOD_DEPTH_OUT = dep_q;
   assign RX_VALID_OUT  = rxv_q;
   assign RX_BIT_OUT    = rxb_q;
   assign RX_END_OUT    = rxe_q;

   property a848_p;
      @(posedge CARRIER_CLK_IN) disable iff (!rst_s2 || !ce_s2)
      (tx_st_q == TX_BIT && tcnt_q == '0 && cmode == nrlc_pkg::MODE_A
       && crate == nrlc_pkg::RATE_848) |-> ##15 (tcnt_q == 10'h00f) ##1 (tcnt_q == '0);
   endproperty
   a848_len_a: assert property (a848_p) else $error("type A bit not 16 cycles");
   property t3_p;
      @(posedge CARRIER_CLK_IN) disable iff (!rst_s2 || !ce_s2)
      (tx_st_q == TX_BIT && tcnt_q == '0 && cmode == nrlc_pkg::MODE_T3
       && crate == nrlc_pkg::RATE_106) |-> ##63 (tcnt_q == 10'h03f);
   endproperty
   t3_len_a: assert property (t3_p) else $error("type 3 bit not 64 cycles");
   a_depth_a: assert property (@(posedge CARRIER_CLK_IN) disable iff (!rst_s2)
      (mod_q && $past(cfg_s2) == cfg_s2 && cmode == nrlc_pkg::MODE_A)
      |-> dep_q == ((crate == nrlc_pkg::RATE_106) ? nrlc_pkg::DEP_FULL : nrlc_pkg::DEP_ASK25))
      else $error("type A depth wrong");
   t5_depth_a: assert property (@(posedge CARRIER_CLK_IN) disable iff (!rst_s2)
      (mod_q && $past(cmode) == nrlc_pkg::MODE_T5) |-> dep_q == nrlc_pkg::DEP_FULL)
      else $error("vicinity depth wrong");
   miller_one_a: assert property (@(posedge CARRIER_CLK_IN) disable iff (!rst_s2 || !ce_s2)
      (tx_st_q == TX_BIT && cmode == nrlc_pkg::MODE_A && tbit_q && tcnt_q < half)
      |=> !mod_q) else $error("miller one paused early");
   b_nrz_a: assert property (@(posedge CARRIER_CLK_IN) disable iff (!rst_s2 || !ce_s2)
      (tx_st_q == TX_BIT && cmode == nrlc_pkg::MODE_B) |=> mod_q == !$past(tbit_q))
      else $error("type B not NRZ");
   t3_manch_a: assert property (@(posedge CARRIER_CLK_IN) disable iff (!rst_s2 || !ce_s2)
      (tx_st_q == TX_BIT && cmode == nrlc_pkg::MODE_T3 && tcnt_q == '0)
      |=> mod_q == !$past(tbit_q)) else $error("type 3 first half wrong");
   a_manch_a: assert property (@(posedge CARRIER_CLK_IN) disable iff (!rst_s2 || !ce_s2)
      (rx_st_q == RX_RUN && rend && cmode == nrlc_pkg::MODE_A && crate == nrlc_pkg::RATE_106
       && e2_q != '0) |=> rxdat_q[0] == ($past(e1_q) >= nrlc_pkg::EDGE_MIN))
      else $error("type A manchester decode wrong");
   b_bpsk_a: assert property (@(posedge CARRIER_CLK_IN) disable iff (!rst_s2 || !ce_s2)
      (rx_st_q == RX_RUN && rend && cmode == nrlc_pkg::MODE_B && !first_q && e1_q != '0)
      |=> rxdat_q[0] == ($past(samp_q) != $past(ref_q)))
      else $error("type B bpsk decode wrong");
   rx_cnt_a: assert property (@(posedge CARRIER_CLK_IN) disable iff (!rst_s2)
      (rx_st_q == RX_RUN) |-> rcnt_q < len) else $error("rx count past bit");
   rx_pass_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN || !CE_IN)
      (rxt_s2 != rxseen_q) |=> RX_VALID_OUT && RX_BIT_OUT == $past(rxdat_q[0]))
      else $error("rx bit not passed to host");
   tx_end_c: cover property (@(posedge CARRIER_CLK_IN) disable iff (!rst_s2)
      tx_st_q == TX_BIT && tlast_q && tend);
   rx_end_c: cover property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
      RX_VALID_OUT && RX_END_OUT);
   rx_bit_c: cover property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
      RX_VALID_OUT && !RX_END_OUT);
endmodule // nrlc_top

// ===== nrlc_card_model.sv
// Purpose: card model driving load modulation back to the reader
// Assumes: bits sent lsb first, first bit opens with a rising edge
// Notes:   unmodulated line rests low
`timescale 1ns/1ps
module nrlc_card_model (
   input  wire logic carrier_clk_in,
   output logic      load_out
);
   initial load_out = 1'b0;
   task automatic send(input int kind, input int len, input logic [15:0] bits, input int n);
      logic lv;
      for (int i = 0; i < n; i++)
      begin
         for (int k = 0; k < len; k++)
         begin
            @(posedge carrier_clk_in);
            // plain manchester, one is high first half
            if (kind == 0)
               lv = (k < len / 2) == bits[i];
            else if (kind == 1)
               lv = ((k < len / 2) == bits[i]) && ((k % 16) < 8);
            // bpsk, subcarrier phase flipped for each one bit
            else
               lv = ((k % 16) < 8) ^ bits[i];
            load_out <= lv;
         end
      end
      @(posedge carrier_clk_in);
      load_out <= 1'b0;
   endtask
endmodule // nrlc_card_model

// ===== test_nrlc_top.sv
// Purpose: self-checking bench for the reader line coder
// Assumes: carrier clock 80 ns, host clock 25 ns
// Notes:   modulation measured in carrier cycles
`timescale 1ns/1ps
module test_nrlc_top;
   logic       clk = 1'b0;
   logic       car_clk = 1'b0;
   logic       rstn = 1'b0;
   logic [2:0] mode = nrlc_pkg::MODE_A;
   logic [1:0] rate = nrlc_pkg::RATE_106;
   logic       tx_valid = 1'b0;
   logic       tx_bit = 1'b0;
   logic       tx_last = 1'b0;
   logic       tx_ready;
   logic       load;
   logic       mod;
   logic [1:0] dep;
   logic       rx_valid;
   logic       rx_bit;
   logic       rx_end;
   logic       arm = 1'b0;
   logic [1:0] rx_q[$];
   int         bad_count = 0;
   int         num_checks = 0;
   int         hi = 0;
   int         first = -1;
   int         last = 0;
   int         cc = 0;

   always #12.5 clk = ~clk;
   always #40 car_clk = ~car_clk;

   nrlc_top dut (.CLOCK_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1), .CARRIER_CLK_IN(car_clk),
      .MODE_IN(mode), .RATE_IN(rate), .TX_VALID_IN(tx_valid), .TX_BIT_IN(tx_bit),
      .TX_LAST_IN(tx_last), .TX_READY_OUT(tx_ready), .LOAD_IN(load), .MOD_OUT(mod),
      .MOD_DEPTH_OUT(dep), .RX_VALID_OUT(rx_valid), .RX_BIT_OUT(rx_bit), .RX_END_OUT(rx_end));
   nrlc_card_model card (.carrier_clk_in(car_clk), .load_out(load));

   always @(negedge car_clk)
   begin
      if (arm)
      begin
         hi = 0;
         first = -1;
         arm = 1'b0;
      end
      cc++;
      if (mod === 1'b1)
      begin
         hi++;
         if (first < 0)
            first = cc;
         last = cc;
      end
   end

   always @(negedge clk)
      if (rx_valid === 1'b1)
         rx_q.push_back({rx_end, rx_bit});

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wc(input int n);
      repeat (n) @(posedge car_clk);
      @(posedge clk);
   endtask

   task automatic setm(input logic [2:0] m, input logic [1:0] r);
      @(posedge clk);
      mode <= m;
      rate <= r;
      wc(8);
   endtask

   task automatic frame(input logic [15:0] bits, input int n);
      int w;
      for (int i = 0; i < n; i++)
      begin
         tx_valid <= 1'b1;
         tx_bit <= bits[i];
         tx_last <= (i == n - 1);
         w = 0;
         @(negedge clk);
         while (tx_ready !== 1'b1 && w < 2000)
         begin
            @(negedge clk);
            w++;
         end
         @(posedge clk);
      end
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
   endtask

   task automatic tx_case(input logic [2:0] m, input logic [1:0] r, input int len,
                          input logic [15:0] bits, input int n, input int eh, input int es,
                          input logic [1:0] ed);
      setm(m, r);
      arm = 1'b1;
      frame(bits, n);
      wc((n + 4) * len);
      chk(hi, eh, "modulated cycles");
      chk(last - first + 1, es, "modulation span");
      chk(dep, ed, "depth class");
   endtask

   task automatic rx_case(input logic [2:0] m, input logic [1:0] r, input int k, input int len,
                          input logic [15:0] bits, input int n);
      setm(m, r);
      rx_q.delete();
      card.send(k, len, bits, n);
      wc(3 * len);
      chk(rx_q.size(), n + 1, "rx count");
      for (int i = 0; i < n; i++)
         chk(rx_q[i], {1'b0, bits[i]}, "rx bit");
      chk(rx_q[n], 2'h2, "rx end");
   endtask

   task automatic test_tx();
      int l;
      for (int r = 0; r < 4; r++)
      begin
         l = 128 >> r;
         tx_case(nrlc_pkg::MODE_A, 2'(r), l, 16'h0001, 3, l / 2, 7 * l / 4,
            (r == 0) ? nrlc_pkg::DEP_FULL : nrlc_pkg::DEP_ASK25);
         tx_case(nrlc_pkg::MODE_B, 2'(r), l, 16'h0002, 3, 2 * l, 3 * l,
            nrlc_pkg::DEP_ASK_B);
         l = (r < 2) ? 64 : 32;
         tx_case(nrlc_pkg::MODE_T3, 2'(r), l, 16'h0002, 2, l, 2 * l,
            nrlc_pkg::DEP_ASK_T3);
      end
      tx_case(nrlc_pkg::MODE_T1, nrlc_pkg::RATE_106, 128, 16'h0001, 3, 64, 224,
         nrlc_pkg::DEP_FULL);
      tx_case(nrlc_pkg::MODE_T5, nrlc_pkg::RATE_848, 512, 16'h0000, 1, 64, 64,
         nrlc_pkg::DEP_FULL);
   endtask

   task automatic test_fill();
      int   acc;
      logic low;
      logic rd;
      acc = 0;
      low = 1'b0;
      setm(nrlc_pkg::MODE_T5, nrlc_pkg::RATE_106);
      arm = 1'b1;
      tx_valid <= 1'b1;
      tx_bit <= 1'b1;
      repeat (40)
      begin
         @(negedge clk);
         rd = tx_ready;
         if (rd !== 1'b1)
            low = 1'b1;
         @(posedge clk);
         if (rd === 1'b1)
            acc++;
      end
      tx_valid <= 1'b0;
      chk(low, 1'b1, "buffer full");
      chk(acc >= 16, 1'b1, "buffer depth");
      wc((acc + 2) * 512);
      chk(hi, 64 * acc, "bits sent");
      chk(tx_ready, 1'b1, "buffer drained");
   endtask

   task automatic test_rx();
      rx_case(nrlc_pkg::MODE_T3, nrlc_pkg::RATE_212, 0, 64, 16'h000b, 4);
      rx_case(nrlc_pkg::MODE_A, nrlc_pkg::RATE_106, 1, 128, 16'h0005, 3);
      rx_case(nrlc_pkg::MODE_A, nrlc_pkg::RATE_212, 2, 64, 16'h0006, 4);
      rx_case(nrlc_pkg::MODE_B, nrlc_pkg::RATE_848, 2, 16, 16'h0002, 3);
      rx_case(nrlc_pkg::MODE_B, nrlc_pkg::RATE_106, 2, 128, 16'h000a, 4);
      rx_case(nrlc_pkg::MODE_T5, nrlc_pkg::RATE_106, 1, 512, 16'h0001, 2);
   endtask

   initial
   begin
      #2500000;
      bad_count++;
      stop_test();
   end

   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      wc(4);
      chk(tx_ready, 1'b1, "ready after reset");
      chk(mod, 1'b0, "idle modulation");
      chk(rx_valid, 1'b0, "idle receive");
      test_tx();
      test_fill();
      test_rx();
      stop_test();
   end
endmodule // test_nrlc_top
